// ### p0gp_board.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// board side of the pads: a source stands behind every pin
module p0gp_board (
    // device drive and board level
    input wire p0gp_pkg::p0gp_drive_t drive_i,
    input wire logic [7:0] ext_level_i,
    // resolved pad level
    output logic [7:0] pad_o
);
    // board source is weak, so a driving device always wins the pad
    assign pad_o = (drive_i.oe & drive_i.out) | (~drive_i.oe & ext_level_i);
endmodule : p0gp_board

// ### p0gp_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// shared constants and carriers of the port 0 pin multiplexer
package p0gp_pkg;

    // port width, one bit per pin
    localparam int unsigned PORT_W = 8;

    // byte offsets of the register words
    localparam logic [4:0] OFF_LATCH = 5'h00;
    localparam logic [4:0] OFF_DIR = 5'h04;
    localparam logic [4:0] OFF_AIDR = 5'h08;
    localparam logic [4:0] OFF_LCD = 5'h0C;
    localparam logic [4:0] OFF_STBY = 5'h10;
    localparam logic [4:0] OFF_PIN = 5'h14;

    // field positions
    localparam int unsigned LCD_LCD_PORT_INPUT_CONTROL_BIT = 0;
    localparam int unsigned LCD_SEL_LSB = 1;
    localparam int unsigned LCD_SEL_W = 7;
    localparam int unsigned STBY_SPL_BIT = 0;

    // reset values
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_AIDR = 8'h00;
    localparam logic [7:0] RST_LCD = 8'h00;
    localparam logic RST_SPL = 1'b0;

    // synchroniser depth for pad inputs
    localparam int unsigned SYNC_STAGES = 2;

    // output drive of a pin group: enable and level
    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] out;
    } p0gp_drive_t;

endpackage : p0gp_pkg

// ### p0gp_sync.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// two-flop level synchroniser, one per bit
module p0gp_sync #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // asynchronous level in, synchronised level out
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule : p0gp_sync

// ### p0gp_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// R01: direction bit one makes the pin a general output port.
// R02: an output port pin drives its data latch bit.
// R03: data writes always load the latch; only output pins drive it.
// R04: reading data for an output pin returns the latch.
// R05: direction bit zero makes the pin a general input port.
// R06: input pin ordinary read gives pin level, read-modify-write gives latch.
// R07: peripheral output enabled drives pin; reads as in R06.
// R08: ordinary read gives pin level even when a peripheral uses it.
// R09: software sets analog disable bit to use pin digitally.
// R10: analog disable register resets to zero, digital input blocked.
// R11: reset clears every direction bit, all pins inputs.
// R12: port use: clear segment select, then set LCD port input control.
// R13: segment use: clear direction, set segment select, then control bit.
// R14: standby pin state with stop or watch: pin floats, input held low.
// R15: under that forcing, interrupt enabled pins keep input open.
// R16: standby pin state zero leaves pins unchanged in stop or watch.
// R17: analog use needs direction and analog disable bits both zero.
// R18: pin level always feeds the external interrupt circuit; under standby forcing the code feeds it only for ext_irq_en_i pins.
// R19: software disables other peripheral outputs before sharing a pin.
// R20: bit n of each register controls pin n.
// R21: read-modify-write reads return the written latch value.
// R22: bus carries a read-modify-write qualifier selecting the latch.
module p0gp_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // avalon-mm register slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic avs_read_modify_write_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // external pads
    input wire logic [7:0] pad_in_i,
    output p0gp_pkg::p0gp_drive_t pad_drive_o,
    // shared peripherals and system
    input wire p0gp_pkg::p0gp_drive_t periph_drive_i,
    input wire logic [7:0] ext_irq_en_i,
    input wire logic stop_watch_i,
    // digital, analog and segment routing
    output logic [7:0] port_in_o,
    output logic [7:0] irq_level_o,
    output logic [7:0] analog_en_o,
    output logic [7:0] lcd_seg_en_o
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0] port0_output_latch_r;
    logic [7:0] port0_direction_r;
    logic [7:0] analog_input_disable_low_r;
    logic [6:0] lcd_segment_select_r;
    logic lcd_port_input_control_r;
    logic standby_pin_state_r;

    logic wait_r;
    logic [31:0] rdata_r;
    p0gp_pkg::p0gp_drive_t drive_r;
    logic [7:0] port_in_r;
    logic [7:0] irq_level_r;
    logic [7:0] analog_en_r;
    logic [7:0] seg_en_r;

    logic [7:0] pad_sync;
    logic req;
    logic wr_go;
    logic lane0;
    logic [7:0] seg_mode;
    logic force_hiz;
    logic [7:0] in_open;
    logic [7:0] dig_in;
    logic [7:0] latch_view;
    logic [7:0] data_view;
    logic [31:0] rdata_nxt;
    p0gp_pkg::p0gp_drive_t drive_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // pad input synchroniser

    p0gp_sync #(
        .W(p0gp_pkg::PORT_W)
    ) u_pad_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(pad_in_i),
        .sync_o(pad_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake

    assign req = avs_read_i | avs_write_i;
    // a write lands only on the edge where waitrequest is seen low
    assign wr_go = avs_write_i & ~wait_r;
    // registers are eight bits wide, so only the low lane matters
    assign lane0 = avs_byteenable_i[0];

    // one wait cycle per access; rises again after the accepting edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= ~(req & wait_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    // R03: latch always written
    // R20: bit n is pin n
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port0_output_latch_r <= p0gp_pkg::RST_LATCH;
        end else if (wr_go && lane0
                     && avs_address_i == p0gp_pkg::OFF_LATCH) begin
            port0_output_latch_r <= avs_writedata_i[7:0];
        end
    end

    // R11: directions clear to inputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port0_direction_r <= p0gp_pkg::RST_DIR;
        end else if (wr_go && lane0
                     && avs_address_i == p0gp_pkg::OFF_DIR) begin
            port0_direction_r <= avs_writedata_i[7:0];
        end
    end

    // R10: analog disable resets zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            analog_input_disable_low_r <= p0gp_pkg::RST_AIDR;
        end else if (wr_go && lane0
                     && avs_address_i == p0gp_pkg::OFF_AIDR) begin
            analog_input_disable_low_r <= avs_writedata_i[7:0];
        end
    end

    // segment select and port input control share one word
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lcd_segment_select_r <=
                p0gp_pkg::RST_LCD[p0gp_pkg::LCD_SEL_LSB +: 7];
            lcd_port_input_control_r <=
                p0gp_pkg::RST_LCD[p0gp_pkg::LCD_LCD_PORT_INPUT_CONTROL_BIT];
        end else if (wr_go && lane0
                     && avs_address_i == p0gp_pkg::OFF_LCD) begin
            lcd_segment_select_r <=
                avs_writedata_i[p0gp_pkg::LCD_SEL_LSB +: 7];
            lcd_port_input_control_r <=
                avs_writedata_i[p0gp_pkg::LCD_LCD_PORT_INPUT_CONTROL_BIT];
        end
    end

    // standby pin state bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            standby_pin_state_r <= p0gp_pkg::RST_SPL;
        end else if (wr_go && lane0
                     && avs_address_i == p0gp_pkg::OFF_STBY) begin
            standby_pin_state_r <= avs_writedata_i[p0gp_pkg::STBY_SPL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin function decode

    // R12: control bit arms select
    // R13: segment pins leave port
    // pin 0 has no segment, so its select is fixed to port
    assign seg_mode = lcd_port_input_control_r
                      ? {lcd_segment_select_r, 1'b0} : 8'h00;

    // R14: forcing in stop/watch
    // R16: bit zero changes nothing
    assign force_hiz = standby_pin_state_r & stop_watch_i;

    // R15: interrupt pins stay open
    assign in_open = force_hiz ? ext_irq_en_i : 8'hFF;

    // R09: disable bit opens input
    // R10: blocked until set; keeps analog pins from leaking
    assign dig_in = pad_sync & analog_input_disable_low_r & in_open;

    ////////////////////////////////////////////////////////////////////////////
    // data register read view

    // R04: output pins read latch
    // R07: peripheral-driven pins read pin
    assign latch_view = port0_direction_r & ~periph_drive_i.oe;

    // R06: input pins read level
    // R08: level despite peripheral input
    // R21: rmw read returns latch
    // R22: qualifier selects latch
    assign data_view = avs_read_modify_write_i ? port0_output_latch_r
                       : (port0_output_latch_r & latch_view)
                         | (dig_in & ~latch_view);

    // read mux; unmapped words and upper bits read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (avs_address_i)
            p0gp_pkg::OFF_LATCH: rdata_nxt[7:0] = data_view;
            p0gp_pkg::OFF_DIR: rdata_nxt[7:0] = port0_direction_r;
            p0gp_pkg::OFF_AIDR: rdata_nxt[7:0] = analog_input_disable_low_r;
            p0gp_pkg::OFF_LCD: begin
                rdata_nxt[p0gp_pkg::LCD_SEL_LSB +: 7] = lcd_segment_select_r;
                rdata_nxt[p0gp_pkg::LCD_LCD_PORT_INPUT_CONTROL_BIT] = lcd_port_input_control_r;
            end
            p0gp_pkg::OFF_STBY:
                rdata_nxt[p0gp_pkg::STBY_SPL_BIT] = standby_pin_state_r;
            p0gp_pkg::OFF_PIN: rdata_nxt[7:0] = pad_sync;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // captured on the first edge so it stands while waitrequest is low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read_i && wait_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad drive

    // R01: direction one enables output
    // R05: direction zero floats pin
    // R02: output drives latch level
    // R07: peripheral enable takes pin
    // R19: peripheral wins; software keeps others off
    always_comb begin
        drive_nxt.out = (periph_drive_i.out & periph_drive_i.oe)
                        | (port0_output_latch_r & ~periph_drive_i.oe);
        drive_nxt.oe = (periph_drive_i.oe | port0_direction_r) & ~seg_mode;
        // R14: forced high impedance
        if (force_hiz) begin
            drive_nxt.oe = 8'h00;
        end
    end

    // pad outputs registered; one cycle after a register write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_r <= '0;
        end else begin
            drive_r <= drive_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // routed inputs and analog/segment enables

    // digital input toward peripherals, held low when blocked
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_in_r <= 8'h00;
        end else begin
            port_in_r <= dig_in;
        end
    end

    // R18: level always to interrupts
    // only the standby block can stop it; analog disable does not
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_level_r <= 8'h00;
        end else begin
            irq_level_r <= pad_sync & in_open;
        end
    end

    // R17: analog needs both zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            analog_en_r <= 8'h00;
        end else begin
            analog_en_r <= ~port0_direction_r
                           & ~analog_input_disable_low_r & ~seg_mode;
        end
    end

    // R13: segment needs direction zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seg_en_r <= 8'h00;
        end else begin
            seg_en_r <= seg_mode & ~port0_direction_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign avs_waitrequest_o = wait_r;
    assign avs_readdata_o = rdata_r;
    assign pad_drive_o = drive_r;
    assign port_in_o = port_in_r;
    assign irq_level_o = irq_level_r;
    assign analog_en_o = analog_en_r;
    assign lcd_seg_en_o = seg_en_r;

endmodule : p0gp_top

// ### p0gp_top_props.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// port-level checks of the port 0 pin multiplexer
module p0gp_top_props (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register bus
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // pins and routing
    input wire logic [7:0] pad_in_i,
    input wire p0gp_pkg::p0gp_drive_t pad_drive_o,
    input wire p0gp_pkg::p0gp_drive_t periph_drive_i,
    input wire logic stop_watch_i,
    input wire logic [7:0] port_in_o,
    input wire logic [7:0] irq_level_o,
    input wire logic [7:0] lcd_seg_en_o
);
    // one domain, so clocking and disable are shared
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////////
    // bus answer timing, segment drive and port input gating
    a_wait_one_cycle: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=>
        !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("wait length");
    a_idle_wait_high: assert property (
        !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("wait dropped idle");
    a_data_stands: assert property (
        !(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o) &&
        avs_readdata_o[31:8] == 24'h000000) else $error("read data moved");
    a_seg_no_drive: assert property (
        (lcd_seg_en_o & pad_drive_o.oe) == 8'h00 && !lcd_seg_en_o[0])
        else $error("segment pin driven");
    a_port_in_gated: assert property (
        (port_in_o & ~irq_level_o) == 8'h00) else $error("port input leak");
    // interrupt feed follows pad, three edges late
    a_irq_follow_pad: assert property (
        $past(rst_n_i, 3) && !$past(stop_watch_i) |->
        irq_level_o == $past(pad_in_i, 3)) else $error("irq level wrong");
    a_in_needs_pad: assert property (
        $past(rst_n_i, 3) |-> (port_in_o & ~$past(pad_in_i, 3)) == 8'h00)
        else $error("port input without pad");
    a_periph_drives: assert property (
        !stop_watch_i |=>
        ($past(periph_drive_i.oe) & ~lcd_seg_en_o & ~pad_drive_o.oe) == 8'h00
        && (($past(periph_drive_i.out) ^ pad_drive_o.out) &
        $past(periph_drive_i.oe) & ~lcd_seg_en_o) == 8'h00)
        else $error("peripheral drive lost");
endmodule : p0gp_top_props

bind p0gp_top p0gp_top_props i_p0gp_top_props (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .pad_in_i(pad_in_i), .pad_drive_o(pad_drive_o),
    .periph_drive_i(periph_drive_i), .stop_watch_i(stop_watch_i),
    .port_in_o(port_in_o), .irq_level_o(irq_level_o),
    .lcd_seg_en_o(lcd_seg_en_o));

// ### p0gp_top_test.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// self-checking bench of the port 0 pin multiplexer
module p0gp_top_test;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h00000000;
    logic [3:0] be = 4'hF;
    logic read_modify_write = 1'b0;
    logic [31:0] rdat;
    logic wt;
    logic [7:0] pad, pin_in, irq, aen, seg;
    logic [7:0] ext = 8'h00;
    logic [7:0] ien = 8'h00;
    logic stop = 1'b0;
    p0gp_pkg::p0gp_drive_t drv;
    p0gp_pkg::p0gp_drive_t pdrv = '0;
    // bench copies of registers and expected levels
    logic [7:0] lat, dir, aid, oe_e, dv, pin, lo, mk;
    logic [7:0] lcdv [3] = '{8'hFF, 8'hFE, 8'h01};
    logic [7:0] lcde [3] = '{8'hFE, 8'h00, 8'h00};
    logic [31:0] expq [$];
    int err_total = 0;
    int samples_checked = 0;
    int seed = 68628;
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    p0gp_top i_p0gp_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_read_modify_write_i(read_modify_write), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .pad_in_i(pad), .pad_drive_o(drv),
        .periph_drive_i(pdrv), .ext_irq_en_i(ien), .stop_watch_i(stop),
        .port_in_o(pin_in), .irq_level_o(irq), .analog_en_o(aen),
        .lcd_seg_en_o(seg));
    p0gp_board i_p0gp_board (.drive_i(drv), .ext_level_i(ext), .pad_o(pad));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // one transfer; request held until wait is seen low at an edge
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [7:0] d, input logic m);
        @(posedge clk_i);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {24'h000000, d};
        read_modify_write <= m;
        // no cycle limit here: the watchdog ends a hung transfer
        do begin
            @(posedge clk_i);
        end while (wt !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
        read_modify_write <= 1'b0;
    endtask : bus
    task automatic rdx(input logic [4:0] a, input logic m, input logic [7:0] e);
        expq.push_back({24'h000000, e});
        bus(1'b0, a, 8'h00, m);
    endtask : rdx
    // every register but the pin word reads zero after reset, latch through the qualifier
    task automatic rst_vals();
        logic [4:0] offs [5];
        offs = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};
        foreach (offs[k]) rdx(offs[k], 1'b1, 8'h00);
    endtask : rst_vals
    // read results are taken at the edge where wait is low
    always @(posedge clk_i) begin
        if (rd && wt === 1'b0 && expq.size() > 0) begin
            chk("readdata", expq.pop_front(), rdat);
        end
    end
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    // watchdog well beyond the roughly 1800 cycles of the run
    initial begin
        #100000;
        err_total++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rst_vals();
        // segment select takes effect only with the control bit
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, 5'h04, 8'h00, 1'b0);
            bus(1'b1, 5'h0C, lcdv[k], 1'b0);
            rdx(5'h0C, 1'b0, lcdv[k]);
            chk("seg", lcde[k], seg);
        end
        // random port setups with peripheral drive
        for (int i = 0; i < 40; i++) begin
            lat = 8'($random(seed));
            dir = 8'($random(seed));
            aid = 8'($random(seed));
            ext <= 8'($random(seed));
            pdrv <= 16'($random(seed));
            bus(1'b1, 5'h00, lat, 1'b0);
            bus(1'b1, 5'h04, dir, 1'b0);
            bus(1'b1, 5'h08, aid, 1'b0);
            be <= 4'hE;
            bus(1'b1, 5'h00, ~lat, 1'b0);
            be <= 4'hF;
            bus(1'b1, 5'h14, 8'hA5, 1'b0);
            repeat (6) @(posedge clk_i);
            oe_e = dir | pdrv.oe;
            dv = (pdrv.oe & pdrv.out) | (~pdrv.oe & lat);
            pin = (oe_e & dv) | (~oe_e & ext);
            lo = dir & ~pdrv.oe;
            chk("oe", oe_e, drv.oe);
            chk("out", dv & oe_e, drv.out & oe_e);
            chk("port_in", pin & aid, pin_in);
            chk("irq", pin, irq);
            chk("analog", 8'(~(dir | aid)), aen);
            rdx(5'h00, 1'b0, (lo & lat) | (~lo & pin & aid));
            rdx(5'h00, 1'b1, lat);
            rdx(5'h04, 1'b0, dir);
            rdx(5'h08, 1'b0, aid);
            rdx(5'h14, 1'b0, pin);
            rdx(5'h18, 1'b0, 8'h00);
            rdx(5'h01, 1'b0, 8'h00);
        end
        // stop mode with and without the pin state bit
        ien <= 8'h0F;
        pdrv <= '0;
        bus(1'b1, 5'h04, 8'hFF, 1'b0);
        for (int s = 1; s >= 0; s--) begin
            bus(1'b1, 5'h10, s[7:0], 1'b0);
            stop <= 1'b1;
            repeat (6) @(posedge clk_i);
            pin = s ? ext : lat;
            mk = s ? ien : 8'hFF;
            chk("oe", s ? 8'h00 : 8'hFF, drv.oe);
            chk("irq", pin & mk, irq);
            chk("port_in", pin & mk & aid, pin_in);
            stop <= 1'b0;
        end
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rst_vals();
        chk("oe", 8'h00, drv.oe);
        final_report();
    end
endmodule : p0gp_top_test
